// *** core/qubp_device.sv ***
// Device end: register access decode for four UART channels
`timescale 1ns/1ps
module qubp_device (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        clk_en,
	qubp_if.device           bus,
	output logic [1:0]       wr_chan,
	output logic [2:0]       wr_addr,
	output logic [7:0]       wr_data,
	output logic             wr_pulse,
	output logic [31:0]      reg_peek
);
	// Two-flop synchronisers on every pin
	logic [11:0] meta_ff;
	logic [11:0] sync_ff;
	logic [7:0]  dmeta_ff;
	logic [7:0]  dsync_ff;
	logic [11:0] pins;
	assign pins = {bus.bus_style, bus.reg_addr, bus.read_strobe_n,
		bus.write_strobe_n, bus.chan_a_select_n, bus.chan_b_select_n,
		bus.chan_c_select_n, bus.chan_d_select_n, 2'b00};
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			meta_ff  <= 12'hfff;
			sync_ff  <= 12'hfff;
			dmeta_ff <= 8'h00;
			dsync_ff <= 8'h00;
		end
		else if (clk_en)
		begin
			meta_ff  <= pins;
			sync_ff  <= meta_ff;
			dmeta_ff <= bus.data_bus;
			dsync_ff <= dmeta_ff;
		end
	end
	logic       style;
	logic [2:0] addr;
	logic       rd_n;
	logic       wr_n;
	logic [3:0] cs_n;
	assign style = sync_ff[11];
	assign addr  = sync_ff[10:8];
	assign rd_n  = sync_ff[7];
	assign wr_n  = sync_ff[6];
	assign cs_n  = sync_ff[5:2];
	// Decode: one active select, a channel and a direction
	logic       sel;
	logic [1:0] chan;
	logic       rd_act;
	logic       wr_act;
	always_comb
	begin
		sel    = 1'b0;
		chan   = 2'b00;
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (style)                                     // RULE_01
		begin
			// Several selects low at once is host error; no channel is selected
			case (cs_n)                                // RULE_06
				4'b0111: begin sel = 1'b1; chan = 2'd0; end
				4'b1011: begin sel = 1'b1; chan = 2'd1; end
				4'b1101: begin sel = 1'b1; chan = 2'd2; end
				4'b1110: begin sel = 1'b1; chan = 2'd3; end // RULE_12
				default: begin sel = 1'b0; chan = 2'd0; end
			endcase
			rd_act = sel && !rd_n;                     // RULE_04
			wr_act = sel && !wr_n;                     // RULE_05
		end
		else
		begin
			// Read strobe and channel D select are not looked at
			sel    = !cs_n[3];                         // RULE_09 RULE_07
			chan   = {cs_n[1], cs_n[2]};   // RULE_10 RULE_11 RULE_13 RULE_12
			rd_act = sel && wr_n;                      // RULE_08
			wr_act = sel && !wr_n;                     // RULE_08
		end
	end
	// Register store per channel
	logic [7:0] regs_ff [qubp_pkg::CHAN_N][qubp_pkg::REG_N];
	logic       wr_act_ff;
	logic [1:0] wchan_ff;
	logic [2:0] waddr_ff;
	// Latch target while write is active; store on strobe release
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_act_ff <= 1'b0;
			wchan_ff  <= 2'd0;
			waddr_ff  <= 3'd0;
		end
		else if (clk_en)
		begin
			wr_act_ff <= wr_act;
			if (wr_act)
			begin
				wchan_ff <= chan;                      // RULE_14
				waddr_ff <= addr;                      // RULE_02
			end
		end
	end
	logic [7:0] wdata_ff;
	always_ff @(posedge clock)
	begin
		if (rst)
			wdata_ff <= 8'h00;
		else if (clk_en && wr_act)
			wdata_ff <= dsync_ff;                      // RULE_03
	end
	logic wr_done;
	assign wr_done = wr_act_ff && !wr_act;             // RULE_05
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int c = 0; c < qubp_pkg::CHAN_N; c++)
				for (int r = 0; r < qubp_pkg::REG_N; r++)
					regs_ff[c][r] <= qubp_pkg::REG_RESET;
		end
		else if (clk_en && wr_done)
			regs_ff[wchan_ff][waddr_ff] <= wdata_ff;   // RULE_05
	end
	// Write notification towards the channel cores
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_chan  <= 2'd0;
			wr_addr  <= 3'd0;
			wr_data  <= 8'h00;
			wr_pulse <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_pulse <= wr_done;
			if (wr_done)
			begin
				wr_chan <= wchan_ff;
				wr_addr <= waddr_ff;
				wr_data <= wdata_ff;
			end
		end
	end
	// Read data drive; enable only during an active read
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			bus.data_dev    <= 8'h00;
			bus.data_dev_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			bus.data_dev_oe <= rd_act;                 // RULE_03
			if (rd_act)
				bus.data_dev <= regs_ff[chan][addr];   // RULE_04 RULE_02
		end
	end
	// Register 0 of every channel, for observation
	genvar g;
	generate
		for (g = 0; g < qubp_pkg::CHAN_N; g++)
		begin : g_peek
			assign reg_peek[g*8 +: 8] = regs_ff[g][0];
		end
	endgenerate
endmodule // qubp_device

// *** core/qubp_host.sv ***
// Host end: drives strobe cycles on the parallel bus
`timescale 1ns/1ps
module qubp_host (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        style_sel,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_chan,
	input  wire logic [2:0]  req_addr,
	input  wire logic [7:0]  req_data,
	output logic             req_ready,
	output logic [7:0]       rsp_data,
	output logic             rsp_valid,
	qubp_if.host             bus
);
	qubp_pkg::qubp_state_t state_ff;
	logic [3:0] cnt_ff;
	logic       write_ff;
	logic [1:0] chan_ff;
	logic [2:0] addr_ff;
	logic [7:0] wdata_ff;
	logic       last;
	assign last = (cnt_ff == qubp_pkg::CNT_ONE);
	assign req_ready = (state_ff == qubp_pkg::QUBP_IDLE);
	// Phase sequencer: setup, strobe active, hold
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_ff <= qubp_pkg::QUBP_IDLE;
			cnt_ff   <= 4'h0;
		end
		else if (clk_en)
		begin
			case (state_ff)
				qubp_pkg::QUBP_IDLE:
					if (req_valid)
					begin
						state_ff <= qubp_pkg::QUBP_SETUP;
						cnt_ff   <= qubp_pkg::SETUP_CNT;
					end
				qubp_pkg::QUBP_SETUP:
					if (last)
					begin
						state_ff <= qubp_pkg::QUBP_ACTIVE;
						cnt_ff   <= qubp_pkg::ACTIVE_CNT;
					end
					else
						cnt_ff <= cnt_ff - 4'h1;
				qubp_pkg::QUBP_ACTIVE:
					if (last)
					begin
						state_ff <= qubp_pkg::QUBP_HOLD;
						cnt_ff   <= qubp_pkg::HOLD_CNT;
					end
					else
						cnt_ff <= cnt_ff - 4'h1;
				qubp_pkg::QUBP_HOLD:
					if (last)
						state_ff <= qubp_pkg::QUBP_IDLE;
					else
						cnt_ff <= cnt_ff - 4'h1;
				default:
					state_ff <= qubp_pkg::QUBP_IDLE;
			endcase
		end
	end
	// Request captured once; held for the whole cycle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			write_ff <= 1'b0;
			chan_ff  <= 2'd0;
			addr_ff  <= 3'd0;
			wdata_ff <= 8'h00;
		end
		else if (clk_en && req_ready && req_valid)
		begin
			write_ff <= req_write;
			chan_ff  <= req_chan;
			addr_ff  <= req_addr;
			wdata_ff <= req_data;
		end
	end
	logic busy;
	logic strobe;
	assign busy   = !req_ready;
	assign strobe = (state_ff == qubp_pkg::QUBP_ACTIVE);
	// Pin drive; style follows style_sel directly, not latched per transfer
	always_comb
	begin
		bus.bus_style       = style_sel;
		bus.reg_addr        = addr_ff;                 // RULE_14
		bus.data_host       = wdata_ff;
		bus.data_host_oe    = busy && write_ff;        // RULE_03
		bus.read_strobe_n   = 1'b1;
		bus.write_strobe_n  = 1'b1;
		bus.chan_a_select_n = 1'b1;
		bus.chan_b_select_n = 1'b1;
		bus.chan_c_select_n = 1'b1;
		bus.chan_d_select_n = 1'b1;
		if (style_sel)
		begin
			bus.read_strobe_n   = !(strobe && !write_ff);   // RULE_04
			bus.write_strobe_n  = !(strobe && write_ff);    // RULE_05
			bus.chan_a_select_n = !(busy && chan_ff == 2'd0);
			bus.chan_b_select_n = !(busy && chan_ff == 2'd1);
			bus.chan_c_select_n = !(busy && chan_ff == 2'd2);
			bus.chan_d_select_n = !(busy && chan_ff == 2'd3);
		end
		else
		begin
			bus.write_strobe_n  = !write_ff;           // RULE_08
			bus.chan_a_select_n = !strobe;             // RULE_09
			bus.chan_b_select_n = chan_ff[0];          // RULE_10 RULE_13
			bus.chan_c_select_n = chan_ff[1];          // RULE_11 RULE_13
		end
	end
	// Sample read data at the strobe's end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rsp_data  <= 8'h00;
			rsp_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			rsp_valid <= strobe && last && !write_ff;
			if (strobe && last && !write_ff)
				rsp_data <= bus.data_bus;              // RULE_04
		end
	end
endmodule // qubp_host

// *** core/qubp_if.sv ***
// Interface joining the host and the device bus ends
`timescale 1ns/1ps
interface qubp_if;
	logic       bus_style;
	logic [2:0] reg_addr;
	logic [7:0] data_host;
	logic       data_host_oe;
	logic [7:0] data_dev;
	logic       data_dev_oe;
	logic       read_strobe_n;
	logic       write_strobe_n;
	logic       chan_a_select_n;
	logic       chan_b_select_n;
	logic       chan_c_select_n;
	logic       chan_d_select_n;
	// Resolved level of the shared data wire; pull-up when undriven
	logic [7:0] data_bus;
	assign data_bus = data_dev_oe ? data_dev
		: (data_host_oe ? data_host : 8'hff);
	modport device (
		input  bus_style,
		input  reg_addr,
		input  data_bus,
		output data_dev,
		output data_dev_oe,
		input  read_strobe_n,
		input  write_strobe_n,
		input  chan_a_select_n,
		input  chan_b_select_n,
		input  chan_c_select_n,
		input  chan_d_select_n
	);
	modport host (
		output bus_style,
		output reg_addr,
		input  data_bus,
		output data_host,
		output data_host_oe,
		output read_strobe_n,
		output write_strobe_n,
		output chan_a_select_n,
		output chan_b_select_n,
		output chan_c_select_n,
		output chan_d_select_n
	);
endinterface

// *** core/qubp_pkg.sv ***
// Package of constants for the quad UART host bus port
//
// Behaviour
// RULE_01: Style pin high selects separate strobes
// RULE_02: Three address lines pick one register
// RULE_03: Eight-bit data bus, device drives reads only
// RULE_04: Read strobe fall reads, host samples at rise
// RULE_05: Write strobe rise stores bus byte
// RULE_06: Four chip selects each enable one channel
// RULE_07: Direction style ignores read strobe
// RULE_08: Write strobe becomes direction, high means read
// RULE_09: Channel A select is single chip select
// RULE_10: Channel B select becomes low channel address
// RULE_11: Channel C select becomes high channel address
// RULE_12: Channel D select unused in direction style
// RULE_13: Channel address 00..11 selects A..D
// RULE_14: Host holds address and selects during strobe
package qubp_pkg;
	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 3;
	localparam int CHAN_N    = 4;
	localparam int CHAN_W    = 2;
	localparam int REG_N     = 8;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Host strobe phases, in 10 ns cycles
	localparam int SETUP_NS  = 30;
	localparam int ACTIVE_NS = 60;
	localparam int HOLD_NS   = 20;
	localparam int CLK_NS    = 10;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACTIVE_CYC = (ACTIVE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);
	localparam logic [3:0] ACTIVE_CNT = 4'(ACTIVE_CYC);
	localparam logic [3:0] HOLD_CNT   = 4'(HOLD_CYC);
	typedef enum logic [1:0] {
		QUBP_IDLE   = 2'b00,
		QUBP_SETUP  = 2'b01,
		QUBP_ACTIVE = 2'b11,
		QUBP_HOLD   = 2'b10
	} qubp_state_t;
endpackage

// *** tb/qubp_assertions.sv ***
// Checker of both bus ends across the joining interface
`timescale 1ns/1ps
module qubp_assertions (
	input logic       clock,
	input logic       rst,
	input logic       bus_style,
	input logic [2:0] reg_addr,
	input logic       data_host_oe,
	input logic       data_dev_oe,
	input logic       read_strobe_n,
	input logic       write_strobe_n,
	input logic       chan_a_select_n,
	input logic       chan_b_select_n,
	input logic       chan_c_select_n,
	input logic       chan_d_select_n
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Strobe phase of either style; style 0 strobes with select A
	logic active;
	assign active = bus_style ? (!read_strobe_n || !write_strobe_n)
		: !chan_a_select_n;
	sequence s_open;
		$rose(active);
	endsequence
	sequence s_read_open;
		s_open ##0 (bus_style ? !read_strobe_n : write_strobe_n);
	endsequence
	sequence s_six_then_off;
		active [*6] ##1 !active;
	endsequence
	// Sync flops add latency, hence a short window
	a_read_drive_on: assert property (s_read_open |-> ##[1:4] data_dev_oe)
		else $error("device did not drive read data");
	a_drive_release: assert property ($fell(active) |-> ##[1:4] !data_dev_oe)
		else $error("device kept driving after strobe");
	a_strobe_six: assert property (s_open |-> s_six_then_off)
		else $error("strobe phase not six cycles");
	a_held_stable: assert property (active && $past(active) |-> $stable(reg_addr) && $stable(write_strobe_n) && $stable({chan_b_select_n, chan_c_select_n}))
		else $error("address or selects moved in strobe");
	a_one_select: assert property (bus_style |-> $onehot0(~{chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n}))
		else $error("more than one select low");
	a_read_unused: assert property (!bus_style |-> read_strobe_n)
		else $error("read strobe moved in direction style");
	a_write_drive: assert property (bus_style && !write_strobe_n |-> data_host_oe && !data_dev_oe)
		else $error("bus owner wrong in strobe write");
	a_dir_write: assert property (!bus_style && active && !write_strobe_n |-> data_host_oe && !data_dev_oe)
		else $error("bus owner wrong in direction write");
endmodule // qubp_assertions

// *** tb/test_quad_uart_host_bus_port.sv ***
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module test_quad_uart_host_bus_port;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        style_sel = 1'b1;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [1:0]  req_chan = 2'h0;
	logic [2:0]  req_addr = 3'h0;
	logic [7:0]  req_data = 8'h00;
	logic        req_ready, rsp_valid, wr_pulse;
	logic [7:0]  rsp_data, wr_data;
	logic [1:0]  wr_chan;
	logic [2:0]  wr_addr;
	logic [31:0] reg_peek;
	logic [7:0]  mem [4][8] = '{default: qubp_pkg::REG_RESET};
	int          n_errors = 0;
	int          checks = 0;
	qubp_if bus_if ();
	// Free-running 100 MHz clock
	always #5 clock = ~clock;
	qubp_host i_qubp_host (.clock(clock), .rst(rst), .clk_en(1'b1),
		.style_sel(style_sel), .req_valid(req_valid), .req_write(req_write),
		.req_chan(req_chan), .req_addr(req_addr), .req_data(req_data),
		.req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
		.bus(bus_if));
	qubp_device i_qubp_device (.clock(clock), .rst(rst), .clk_en(1'b1),
		.bus(bus_if), .wr_chan(wr_chan), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_pulse(wr_pulse), .reg_peek(reg_peek));
	qubp_assertions i_qubp_assertions (.clock(clock), .rst(rst),
		.bus_style(bus_if.bus_style), .reg_addr(bus_if.reg_addr),
		.data_host_oe(bus_if.data_host_oe), .data_dev_oe(bus_if.data_dev_oe),
		.read_strobe_n(bus_if.read_strobe_n),
		.write_strobe_n(bus_if.write_strobe_n),
		.chan_a_select_n(bus_if.chan_a_select_n),
		.chan_b_select_n(bus_if.chan_b_select_n),
		.chan_c_select_n(bus_if.chan_c_select_n),
		.chan_d_select_n(bus_if.chan_d_select_n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Channel registers 0 as the device exposes them
	function automatic logic [31:0] peek_exp();
		return {mem[3][0], mem[2][0], mem[1][0], mem[0][0]};
	endfunction
	// One transfer; waits are bounded so a dead end cannot hang
	task automatic xfer(input logic st, input logic wr, input logic [1:0] ch,
		input logic [2:0] ad, input logic [7:0] dt);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 40)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		check({31'h0, k < 40}, 32'h1, "host never ready");
		style_sel = st;
		{req_valid, req_write, req_chan, req_addr, req_data} = {1'b1, wr, ch, ad, dt};
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		k = 0;
		while ((wr ? wr_pulse : rsp_valid) !== 1'b1 && k < 40)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		check({31'h0, k < 40}, 32'h1, "transfer never ended");
		if (wr)
		begin
			mem[ch][ad] = dt;
			check({wr_chan, wr_addr, wr_data}, {ch, ad, dt}, "stored write");
			check(reg_peek, peek_exp(), "register view");
		end
		else
			check(rsp_data, mem[ch][ad], "read data");
	endtask
	// Watchdog well beyond the expected few thousand cycles
	initial
	begin
		#400000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		wrap_up();
	end
	initial
	begin
		logic [14:0] r;
		r = 15'($urandom(32'h1ac1c32f));
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		// Reset contents, alternating bus styles
		for (int c = 0; c < 4; c++)
			for (int a = 0; a < 8; a++)
				xfer(a[0], 1'b0, 2'(c), 3'(a), 8'h00);
		$display("Test 1 done");
		// Strobe-style writes with edge data, read back by direction style
		for (int c = 0; c < 4; c++)
			for (int a = 0; a < 8; a++)
				xfer(1'b1, 1'b1, 2'(c), 3'(a), a == 0 ? 8'hff : a == 7 ? 8'h00 : 8'($urandom));
		for (int c = 0; c < 4; c++)
			for (int a = 0; a < 8; a++)
				xfer(1'b0, 1'b0, 2'(c), 3'(a), 8'h00);
		$display("Test 2 done");
		// Random mix of styles and directions, back to back
		repeat (60)
		begin
			r = 15'($urandom);
			xfer(r[14], r[13], r[12:11], r[10:8], r[7:0]);
		end
		$display("Test 3 done");
		wrap_up();
	end
endmodule // test_quad_uart_host_bus_port
